// >>> src/cl_six_bit_lock.v
// Six-bit combination lock with stored-code and trial registers
`timescale 1ns/1ps
`include "cl_lock_defs.vh"

module cl_six_bit_lock #(
    parameter CODE_W = `CL_CODE_W,
    parameter OUT_W = `CL_OUT_W
) (
    input wire clk,
    input wire rst_n,
    input wire stepPin,
    input wire clearPin,
    input wire [CODE_W-1:0] comboPin,
    output reg [OUT_W-1:0] lockOut
);

    // Binary codes of the one-bit state flag
    localparam [0:0] ST_REGISTER = `CL_ST_REGISTER;
    localparam [0:0] ST_ATTEMPT = `CL_ST_ATTEMPT;

    // Per-bit equality, an inverted exclusive-or for every pair
    function [CODE_W-1:0] bitsEqual;
        input [CODE_W-1:0] a;
        input [CODE_W-1:0] b;
        begin
            bitsEqual = ~(a ^ b);
        end
    endfunction

    // A match needs every pair equal, not just most of them
    function codesMatch;
        input [CODE_W-1:0] a;
        input [CODE_W-1:0] b;
        begin
            codesMatch = &bitsEqual(a, b);
        end
    endfunction

    // Low-to-high change between two samples of one level
    function risingEdge;
        input cur;
        input prev;
        begin
            risingEdge = cur & ~prev;
        end
    endfunction

    // Pins are asynchronous to clk; two flops before any use
    reg stepMeta_q;
    reg stepSync_q;
    reg stepPrev_q;
    reg clearMeta_q;
    reg clearSync_q;
    reg [CODE_W-1:0] comboMeta_q;
    reg [CODE_W-1:0] comboSync_q;

    // Lock state, with next values worked out combinationally
    reg state_q;
    reg state_d;
    reg [CODE_W-1:0] storedCode_q;
    reg [CODE_W-1:0] storedCode_d;
    reg [CODE_W-1:0] trialCode_q;
    reg [CODE_W-1:0] trialCode_d;
    reg [OUT_W-1:0] lockOut_d;

    wire stepEdge;
    wire clearNow;
    wire codeStored;
    wire codesEqual;
    wire unlocked;

    // Idle level of the buttons is low, so no false edge after reset
    always @(posedge clk) begin
        if (!rst_n) begin
            stepMeta_q <= `CL_PIN_RST;
            stepSync_q <= `CL_PIN_RST;
        end else begin
            stepMeta_q <= stepPin;
            stepSync_q <= stepMeta_q;
        end
    end

    // Third flop only remembers the synced level for edge finding
    always @(posedge clk) begin
        if (!rst_n) begin
            stepPrev_q <= `CL_PIN_RST;
        end else begin
            stepPrev_q <= stepSync_q;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            clearMeta_q <= `CL_PIN_RST;
            clearSync_q <= `CL_PIN_RST;
        end else begin
            clearMeta_q <= clearPin;
            clearSync_q <= clearMeta_q;
        end
    end

    // Switches pass the same two flops, so code and step stay aligned
    always @(posedge clk) begin
        if (!rst_n) begin
            comboMeta_q <= `CL_CODE_RST;
            comboSync_q <= `CL_CODE_RST;
        end else begin
            comboMeta_q <= comboPin;
            comboSync_q <= comboMeta_q;
        end
    end

    // A press is a rising level; stepEdge is a one-clk enable, clk stays the lock's clock
    assign stepEdge = risingEdge(stepSync_q, stepPrev_q);
    assign clearNow = clearSync_q;

    // Clear wins over a step that lands in the same cycle
    always @* begin
        state_d = state_q;
        if (clearNow) begin
            state_d = ST_REGISTER;
        end else if (stepEdge) begin
            case (state_q)
                ST_REGISTER: begin
                    state_d = ST_ATTEMPT;
                end
                ST_ATTEMPT: begin
                    state_d = ST_ATTEMPT;
                end
                default: begin
                    state_d = ST_REGISTER;
                end
            endcase
        end
    end

    // Stored code loads only in the registering state; clear zeroes it in either state
    always @* begin
        storedCode_d = storedCode_q;
        if (clearNow) begin
            storedCode_d = `CL_CODE_RST;
        end else if (stepEdge && (state_q == ST_REGISTER)) begin
            storedCode_d = comboSync_q;
        end
    end

    // Trial follows every step once a code is stored
    always @* begin
        trialCode_d = trialCode_q;
        if (clearNow) begin
            trialCode_d = `CL_CODE_RST;
        end else if (stepEdge && (state_q == ST_ATTEMPT)) begin
            trialCode_d = comboSync_q;
        end
    end

    // Synchronous reset clears everything, whatever the step does
    always @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_REGISTER;
        end else begin
            state_q <= state_d;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            storedCode_q <= `CL_CODE_RST;
        end else begin
            storedCode_q <= storedCode_d;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            trialCode_q <= `CL_CODE_RST;
        end else begin
            trialCode_q <= trialCode_d;
        end
    end

    // Limitation: an all-zero stored code opens before any attempt
    assign codeStored = (state_q == ST_ATTEMPT);
    assign codesEqual = codesMatch(storedCode_q, trialCode_q);

    // Cleared registers compare equal, so gate by the state flag
    assign unlocked = codeStored & codesEqual;

    always @* begin
        if (unlocked) begin
            lockOut_d = {OUT_W{1'h1}};
        end else begin
            lockOut_d = {OUT_W{1'h0}};
        end
    end

    // Output straight from a flop, one clk after the compare settles
    always @(posedge clk) begin
        if (!rst_n) begin
            lockOut <= `CL_OUT_RST;
        end else begin
            lockOut <= lockOut_d;
        end
    end

endmodule // cl_six_bit_lock

// >>> src/cl_lock_defs.vh
// Constants for the six-bit combination lock
`ifndef CL_LOCK_DEFS_VH
`define CL_LOCK_DEFS_VH

`define CL_CODE_W 6
`define CL_OUT_W 8
`define CL_CODE_RST 6'h00
`define CL_OUT_RST 8'h00
`define CL_PIN_RST 1'h0
`define CL_ST_REGISTER 1'h0
`define CL_ST_ATTEMPT 1'h1

`endif

// >>> sim/cl_lock_props.sv
// Lock output checker
`timescale 1ns/1ps
module cl_lock_props #(
    parameter OUT_W = 8
) (
    input wire clk,
    input wire rst_n,
    input wire stepPin,
    input wire clearPin,
    input wire [OUT_W-1:0] lockOut
);
    chk_outs_agree: assert property (@(posedge clk) disable iff (!rst_n)
        lockOut == {OUT_W{1'h0}} || lockOut == {OUT_W{1'h1}})
        else $error("outputs differ");
    chk_reset_locked: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> lockOut == {OUT_W{1'h0}})
        else $error("open at reset");
    // Clear seen at four edges: regs cleared three edges in, output at the fourth
    chk_clear_locks: assert property (@(posedge clk) disable iff (!rst_n)
        clearPin [*4] |=> lockOut == {OUT_W{1'h0}})
        else $error("open in clear");
    chk_reset_clears: assert property (@(posedge clk)
        !rst_n |=> lockOut == {OUT_W{1'h0}})
        else $error("open after reset");
    // Two sync flops, state flop, output flop; the edge flop adds no delay
    chk_open_after_step: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(lockOut[0]) |-> $past(stepPin, 4))
        else $error("opened without step");
    chk_lock_steady: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(lockOut) |-> $past(stepPin, 4) || $past(clearPin, 4) || !$past(rst_n))
        else $error("output moved alone");
endmodule // cl_lock_props
bind cl_six_bit_lock cl_lock_props #(
    .OUT_W(OUT_W)
) props (
    .clk(clk),
    .rst_n(rst_n),
    .stepPin(stepPin),
    .clearPin(clearPin),
    .lockOut(lockOut)
);

// >>> sim/cl_user_model.sv
// User at the buttons and switches
`timescale 1ns/1ps
module cl_user_model (
    input wire clk,
    output reg stepPin = 1'h0,
    output reg clearPin = 1'h0,
    output reg [5:0] comboPin = 6'h00
);
    // Held 4 cycles so the synchronisers always see it
    task act(input k, input [5:0] c); begin
        @(negedge clk);
        comboPin = c;
        {clearPin, stepPin} = k ? 2'h2 : 2'h1;
        repeat (4) @(negedge clk);
        {clearPin, stepPin} = 2'h0;
        repeat (4) @(negedge clk);
    end endtask
endmodule // cl_user_model

// >>> sim/testbench.sv
// Lock bench
`timescale 1ns/1ps
module testbench;
    reg clk = 1'h0;
    reg rst_n = 1'h0;
    wire stepPin;
    wire clearPin;
    wire [5:0] comboPin;
    wire [7:0] lockOut;
    integer fails = 0;
    integer checkCount = 0;
    integer cycleCount = 0;
    integer i;
    always #2 clk = ~clk;
    cl_six_bit_lock dut (
        .clk(clk),
        .rst_n(rst_n),
        .stepPin(stepPin),
        .clearPin(clearPin),
        .comboPin(comboPin),
        .lockOut(lockOut)
    );
    cl_user_model user (
        .clk(clk),
        .stepPin(stepPin),
        .clearPin(clearPin),
        .comboPin(comboPin)
    );
    task conclude; begin
        if (fails == 0 && checkCount > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    end endtask
    // Scenarios need about 134 cycles; far beyond that means a hang
    always @(posedge clk) begin
        cycleCount = cycleCount + 1;
        if (cycleCount == 500) begin
            fails = fails + 1;
            conclude;
        end
    end
    task chk(input [7:0] e); begin
        checkCount = checkCount + 1;
        if (lockOut !== e) begin
            fails = fails + 1;
            $display("wrong value %0t lock %h want %h", $time, lockOut, e);
        end
    end endtask
    task t_match; begin
        user.act(1'h0, 6'h2d);
        chk(8'h00);
        user.act(1'h0, 6'h2d);
        chk(8'hff);
        for (i = 0; i < 6; i = i + 1) begin
            user.act(1'h0, 6'h2d ^ (6'h01 << i));
            chk(8'h00);
        end
        user.act(1'h0, 6'h2d);
        chk(8'hff);
    end endtask
    task t_clear; begin
        user.act(1'h1, 6'h2d);
        chk(8'h00);
        user.act(1'h0, 6'h13);
        chk(8'h00);
        user.act(1'h0, 6'h13);
        chk(8'hff);
    end endtask
    // Mid-run reset: first step afterwards must store, not try
    task t_reset; begin
        rst_n = 1'h0;
        repeat (4) @(negedge clk);
        chk(8'h00);
        rst_n = 1'h1;
        user.act(1'h0, 6'h3f);
        chk(8'h00);
        user.act(1'h0, 6'h3f);
        chk(8'hff);
    end endtask
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'h1;
        chk(8'h00);
        t_match;
        t_clear;
        t_reset;
        conclude;
    end
endmodule // testbench
